// *** verilog/clsro_defines.vh ***
`ifndef CLSRO_DEFINES_VH
`define CLSRO_DEFINES_VH
// opcodes
`define CLSRO_OP_OR_DIR_ACC  8'h42
`define CLSRO_OP_OR_ACC_IMM  8'h44
`define CLSRO_OP_OR_DIR_IMM  8'h43
`define CLSRO_OP_OR_C_BIT    8'h72
`define CLSRO_OP_OR_C_NBIT   8'hA0
`define CLSRO_OP_PULL        8'hD0
`define CLSRO_OP_STORE       8'hC0
`define CLSRO_OP_SUB_EXIT    8'h22
`define CLSRO_OP_INT_EXIT    8'h32
`define CLSRO_OP_ROT_L       8'h23
`define CLSRO_OP_ROT_LC      8'h33
`define CLSRO_OP_ROT_R       8'h03
`define CLSRO_OP_ROT_RC      8'h13
`define CLSRO_OP_SET_C       8'hD3
`define CLSRO_OP_SET_BIT     8'hD2
// cycles per instruction
`define CLSRO_CYC_ONE        2'h1
`define CLSRO_CYC_TWO        2'h2
// direct addresses of the special registers held here
`define CLSRO_ADR_SP         8'h81
`define CLSRO_ADR_PORT1      8'h90
`define CLSRO_ADR_PSW        8'hD0
`define CLSRO_ADR_ACC        8'hE0
// bit-addressable low ram base
`define CLSRO_BIT_RAM_BASE   4'h2
// carry position in the status word
`define CLSRO_CY_BIT         7
// reset values
`define CLSRO_RST_SP         8'h07
`define CLSRO_RST_ACC        8'h00
`define CLSRO_RST_PSW        8'h00
`define CLSRO_RST_PORT       8'hFF
`define CLSRO_RST_PC         16'h0000
`endif

// *** verilog/clsro_exec.v ***
// Overview of operation
// - or into direct byte from acc, or acc with immediate: 2 bytes, 1 cycle
// - or of direct byte with immediate: 3 bytes, 2 cycles, result to direct
// - carry or sets carry when source bit is one; 2 bytes, 2 cycles
// - complemented form uses inverted bit; addressed bit left unchanged
// - stack pull reads ram at pointer, decrements, writes direct byte
// - pulling into stack pointer: decrement first, popped value wins
// - stack store increments pointer then copies direct byte to ram there
// - subroutine exit pops pc high then low, pointer down two, 2 cycles
// - interrupt exit also reopens the serviced priority level
// - interrupt exit alters only pc, pointer, priority state and the post-exit hold
// - after interrupt exit one instruction runs before pending service
// - rotate left: bit 7 to bit 0, carry unchanged
// - rotate left through carry: bit 7 to carry, carry to bit 0
// - rotate right: bit 0 to bit 7, carry unchanged
// - rotate right through carry: bit 0 to carry, carry to bit 7
// - force carry high: 1 byte, 1 cycle
// - force direct bit high: 2 bytes, 1 cycle
// - read-modify-write of output port uses its latch, not the pins
`timescale 1ns/1ps
`include "clsro_defines.vh"
module clsro_exec (
  input  wire        clk_sys,
  input  wire        rst_b,
  input  wire        ins_valid,
  input  wire [7:0]  ins_op,
  input  wire [7:0]  ins_b1,
  input  wire [7:0]  ins_b2,
  input  wire        irq_enter,
  input  wire        irq_enter_hi,
  input  wire        irq_pend_le,
  output reg         busy_q,
  output reg         done_q,
  output reg         bad_op_q,
  output reg  [7:0]  acc_q,
  output reg  [7:0]  psw_q,
  output reg  [7:0]  sp_q,
  output reg  [15:0] pc_q,
  output reg  [7:0]  port1_q,
  output reg  [1:0]  in_svc_q,
  output reg         irq_hold_q
);
  // not reset: the stack area is for software to set up
  reg [7:0] ram [0:255];
  reg [7:0] op_q;
  reg [7:0] b1_q;
  reg [7:0] val_q;
  reg       bit_q;
  reg [7:0] bsel_adr;
  reg [7:0] bsel;

  // port reads return the output latch: there are no pin inputs here
  function [7:0] rd_dir;
    input [7:0] a;
    begin
      case (a)
        `CLSRO_ADR_ACC:   rd_dir = acc_q;
        `CLSRO_ADR_SP:    rd_dir = sp_q;
        `CLSRO_ADR_PSW:   rd_dir = psw_q;
        `CLSRO_ADR_PORT1: rd_dir = port1_q;
        default:          rd_dir = ram[a];
      endcase
    end
  endfunction

  // low bit addresses fall in the bit-addressable ram bytes
  function [7:0] bit_byte;
    input [7:0] ba;
    begin
      if (ba[7])
        bit_byte = {ba[7:3], 3'b000};
      else
        bit_byte = {`CLSRO_BIT_RAM_BASE, ba[6:3]};
    end
  endfunction

  function [7:0] bit_mask;
    input [2:0] n;
    begin
      bit_mask = 8'h01 << n;
    end
  endfunction

  // cycle count per opcode; refused opcodes finish on the take edge
  function [1:0] ins_cycles;
    input [7:0] o;
    begin
      case (o)
        `CLSRO_OP_OR_DIR_ACC: ins_cycles = `CLSRO_CYC_ONE;
        `CLSRO_OP_OR_ACC_IMM: ins_cycles = `CLSRO_CYC_ONE;
        `CLSRO_OP_OR_DIR_IMM: ins_cycles = `CLSRO_CYC_TWO;
        `CLSRO_OP_OR_C_BIT:   ins_cycles = `CLSRO_CYC_TWO;
        `CLSRO_OP_OR_C_NBIT:  ins_cycles = `CLSRO_CYC_TWO;
        `CLSRO_OP_PULL:       ins_cycles = `CLSRO_CYC_TWO;
        `CLSRO_OP_STORE:      ins_cycles = `CLSRO_CYC_TWO;
        `CLSRO_OP_SUB_EXIT:   ins_cycles = `CLSRO_CYC_TWO;
        `CLSRO_OP_INT_EXIT:   ins_cycles = `CLSRO_CYC_TWO;
        `CLSRO_OP_ROT_L:      ins_cycles = `CLSRO_CYC_ONE;
        `CLSRO_OP_ROT_LC:     ins_cycles = `CLSRO_CYC_ONE;
        `CLSRO_OP_ROT_R:      ins_cycles = `CLSRO_CYC_ONE;
        `CLSRO_OP_ROT_RC:     ins_cycles = `CLSRO_CYC_ONE;
        `CLSRO_OP_SET_C:      ins_cycles = `CLSRO_CYC_ONE;
        `CLSRO_OP_SET_BIT:    ins_cycles = `CLSRO_CYC_ONE;
        default:              ins_cycles = `CLSRO_CYC_ONE;
      endcase
    end
  endfunction

  task wr_dir;
    input [7:0] a;
    input [7:0] d;
    begin
      case (a)
        `CLSRO_ADR_ACC:   acc_q <= d;
        `CLSRO_ADR_SP:    sp_q <= d;
        `CLSRO_ADR_PSW:   psw_q <= d;
        `CLSRO_ADR_PORT1: port1_q <= d;
        default:          ram[a] <= d;
      endcase
    end
  endtask

  // decides when a post-exit hold may drop
  wire       one_cyc = (ins_cycles(ins_op) == `CLSRO_CYC_ONE);
  wire       bval    = bsel[ins_b1[2:0]];
  wire       cy      = psw_q[`CLSRO_CY_BIT];

  // spelled out, not a function call in an assign: an assign wakes only
  // on its arguments and would miss acc, pointer and ram updates
  always @* begin
    bsel_adr = bit_byte(ins_b1);
    case (bsel_adr)
      `CLSRO_ADR_ACC:   bsel = acc_q;
      `CLSRO_ADR_SP:    bsel = sp_q;
      `CLSRO_ADR_PSW:   bsel = psw_q;
      `CLSRO_ADR_PORT1: bsel = port1_q;
      default:          bsel = ram[bsel_adr];
    endcase
  end

  always @(posedge clk_sys) begin
    if (!rst_b) begin
      busy_q     <= 1'b0;
      done_q     <= 1'b0;
      bad_op_q   <= 1'b0;
      acc_q      <= `CLSRO_RST_ACC;
      psw_q      <= `CLSRO_RST_PSW;
      sp_q       <= `CLSRO_RST_SP;
      pc_q       <= `CLSRO_RST_PC;
      port1_q    <= `CLSRO_RST_PORT;
      in_svc_q   <= 2'b00;
      irq_hold_q <= 1'b0;
      op_q       <= 8'h00;
      b1_q       <= 8'h00;
      val_q      <= 8'h00;
      bit_q      <= 1'b0;
    end else begin
      done_q   <= 1'b0;
      bad_op_q <= 1'b0;
      // an entry here outlasts an exit's clear later in this block
      if (irq_enter) begin
        in_svc_q[irq_enter_hi] <= 1'b1;
      end
      if (!busy_q && ins_valid) begin
        op_q <= ins_op;
        b1_q <= ins_b1;
        // the instruction after an exit clears the hold as it completes
        // two-cycle ops other than interrupt exit drop it on their second edge, below
        if (irq_hold_q && one_cyc) begin
          irq_hold_q <= 1'b0;
        end
        case (ins_op)
          `CLSRO_OP_OR_DIR_ACC: begin
            wr_dir(ins_b1, rd_dir(ins_b1) | acc_q);
            pc_q   <= pc_q + 16'h0002;
            done_q <= 1'b1;
          end
          `CLSRO_OP_OR_ACC_IMM: begin
            acc_q  <= acc_q | ins_b1;
            pc_q   <= pc_q + 16'h0002;
            done_q <= 1'b1;
          end
          `CLSRO_OP_OR_DIR_IMM: begin
            val_q  <= rd_dir(ins_b1) | ins_b2;
            busy_q <= 1'b1;
          end
          `CLSRO_OP_OR_C_BIT: begin
            bit_q  <= bval;
            busy_q <= 1'b1;
          end
          `CLSRO_OP_OR_C_NBIT: begin
            bit_q  <= ~bval;
            busy_q <= 1'b1;
          end
          `CLSRO_OP_PULL: begin
            val_q  <= ram[sp_q];
            sp_q   <= sp_q - 8'h01;
            busy_q <= 1'b1;
          end
          `CLSRO_OP_STORE: begin
            sp_q   <= sp_q + 8'h01;
            // taken now, so a push of the pointer stores its old value
            val_q  <= rd_dir(ins_b1);
            busy_q <= 1'b1;
          end
          `CLSRO_OP_SUB_EXIT, `CLSRO_OP_INT_EXIT: begin
            val_q  <= ram[sp_q];
            sp_q   <= sp_q - 8'h01;
            busy_q <= 1'b1;
          end
          `CLSRO_OP_ROT_L: begin
            acc_q  <= {acc_q[6:0], acc_q[7]};
            pc_q   <= pc_q + 16'h0001;
            done_q <= 1'b1;
          end
          `CLSRO_OP_ROT_LC: begin
            acc_q  <= {acc_q[6:0], cy};
            psw_q[`CLSRO_CY_BIT] <= acc_q[7];
            pc_q   <= pc_q + 16'h0001;
            done_q <= 1'b1;
          end
          `CLSRO_OP_ROT_R: begin
            acc_q  <= {acc_q[0], acc_q[7:1]};
            pc_q   <= pc_q + 16'h0001;
            done_q <= 1'b1;
          end
          `CLSRO_OP_ROT_RC: begin
            acc_q  <= {cy, acc_q[7:1]};
            psw_q[`CLSRO_CY_BIT] <= acc_q[0];
            pc_q   <= pc_q + 16'h0001;
            done_q <= 1'b1;
          end
          `CLSRO_OP_SET_C: begin
            psw_q[`CLSRO_CY_BIT] <= 1'b1;
            pc_q   <= pc_q + 16'h0001;
            done_q <= 1'b1;
          end
          `CLSRO_OP_SET_BIT: begin
            wr_dir(bit_byte(ins_b1),
                   bsel | bit_mask(ins_b1[2:0]));
            pc_q   <= pc_q + 16'h0002;
            done_q <= 1'b1;
          end
          default: begin
            // opcodes outside this slice are refused, pc left alone
            bad_op_q <= 1'b1;
            done_q   <= 1'b1;
          end
        endcase
      end else if (busy_q) begin
        busy_q <= 1'b0;
        done_q <= 1'b1;
        if (irq_hold_q && (op_q != `CLSRO_OP_INT_EXIT)) begin
          irq_hold_q <= 1'b0;
        end
        case (op_q)
          `CLSRO_OP_OR_DIR_IMM: begin
            wr_dir(b1_q, val_q);
            pc_q <= pc_q + 16'h0003;
          end
          `CLSRO_OP_OR_C_BIT, `CLSRO_OP_OR_C_NBIT: begin
            // only sets; a zero operand leaves the carry as it was
            if (bit_q) begin
              psw_q[`CLSRO_CY_BIT] <= 1'b1;
            end
            pc_q <= pc_q + 16'h0002;
          end
          `CLSRO_OP_PULL: begin
            // pointer already decremented, so a pull into it wins
            wr_dir(b1_q, val_q);
            pc_q <= pc_q + 16'h0002;
          end
          `CLSRO_OP_STORE: begin
            ram[sp_q] <= val_q;
            pc_q <= pc_q + 16'h0002;
          end
          `CLSRO_OP_SUB_EXIT: begin
            pc_q <= {val_q, ram[sp_q]};
            sp_q <= sp_q - 8'h01;
          end
          `CLSRO_OP_INT_EXIT: begin
            // status word is not restored; software must do it
            pc_q <= {val_q, ram[sp_q]};
            sp_q <= sp_q - 8'h01;
            // only the highest level in service is reopened
            if (in_svc_q[1]) begin
              in_svc_q[1] <= irq_enter && irq_enter_hi;
            end else begin
              in_svc_q[0] <= irq_enter && !irq_enter_hi;
            end
            irq_hold_q <= irq_pend_le;
          end
          default: begin
            // not reached: busy is only raised by the ops above
            pc_q <= pc_q;
          end
        endcase
      end
    end
  end
endmodule

// *** verification/clsro_exec_assertions.sv ***
`timescale 1ns/1ps
module clsro_exec_assertions (
  input wire       clk_sys,
  input wire       rst_b,
  input wire       ins_valid,
  input wire [7:0] ins_op,
  input wire       busy_q,
  input wire       done_q,
  input wire [7:0] acc_q,
  input wire [7:0] psw_q,
  input wire [7:0] sp_q,
  input wire       irq_hold_q
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  wire tk = ins_valid && !busy_q;
  property p_rl; tk && ins_op == 8'h23 |=> psw_q == $past(psw_q)
    && acc_q == (($past(acc_q) << 1) | ($past(acc_q) >> 7)); endproperty
  a_rl: assert property (p_rl) else $error("rotate left");
  property p_rr; tk && ins_op == 8'h03 |=> psw_q == $past(psw_q)
    && acc_q == (($past(acc_q) >> 1) | ($past(acc_q) << 7)); endproperty
  a_rr: assert property (p_rr) else $error("rotate right");
  property p_sc; tk && ins_op == 8'hD3 |=> psw_q[7] && $stable(acc_q);
  endproperty
  a_sc: assert property (p_sc) else $error("carry force");
  property p_pl; tk && ins_op == 8'hD0 |=> sp_q == $past(sp_q) - 8'h01;
  endproperty
  a_pl: assert property (p_pl) else $error("pull pointer");
  property p_ps; tk && ins_op == 8'hC0 |=> sp_q == $past(sp_q) + 8'h01;
  endproperty
  a_ps: assert property (p_ps) else $error("store pointer");
  property p_ex; tk && (ins_op == 8'h22 || ins_op == 8'h32) |=> busy_q
    ##1 done_q && sp_q == $past(sp_q, 2) - 8'h02; endproperty
  a_ex: assert property (p_ex) else $error("exit timing");
  // psw is left alone, so the handler must restore it by itself
  property p_rt; tk && ins_op == 8'h32 |=> ##1 psw_q == $past(psw_q, 2)
    && acc_q == $past(acc_q, 2); endproperty
  a_rt: assert property (p_rt) else $error("exit side effect");
  property p_2c; tk && (ins_op == 8'h43 || ins_op == 8'h72 ||
    ins_op == 8'hA0) |=> busy_q && !done_q ##1 !busy_q && done_q;
  endproperty
  a_2c: assert property (p_2c) else $error("two cycle op");
  property p_1c; tk && (ins_op == 8'h44 || ins_op == 8'h42 ||
    ins_op == 8'hD2) |=> done_q && !busy_q; endproperty
  a_1c: assert property (p_1c) else $error("one cycle op");
  property p_hd; $fell(irq_hold_q) |-> done_q; endproperty
  a_hd: assert property (p_hd) else $error("hold release");
endmodule
bind clsro_exec clsro_exec_assertions clsro_exec_assertions_inst (
  .clk_sys(clk_sys), .rst_b(rst_b), .ins_valid(ins_valid),
  .ins_op(ins_op), .busy_q(busy_q), .done_q(done_q), .acc_q(acc_q),
  .psw_q(psw_q), .sp_q(sp_q), .irq_hold_q(irq_hold_q));

// *** verification/clsro_exec_bench.sv ***
`timescale 1ns/1ps
module clsro_exec_bench;
  localparam [71:0] OPS = 72'h23_03_33_13_D3_D2_72_A0_42;
  reg clk_sys = 1'b0, rst_b = 1'b0, ins_valid = 1'b0, bad = 1'b0;
  reg irq_enter = 1'b0, irq_enter_hi = 1'b0, irq_pend_le = 1'b0;
  reg [7:0] ins_op = 8'h00, ins_b1 = 8'h00, ins_b2 = 8'h00;
  wire busy_q, done_q, bad_op_q, irq_hold_q;
  wire [7:0] acc_q, psw_q, sp_q, port1_q;
  wire [15:0] pc_q;
  wire [1:0] in_svc_q;
  integer bad_count = 0, num_checks = 0, seed = 32'h8454, i, j, k, n;
  reg [7:0] r, m, op, b;
  reg [16:0] st;
  always #25 clk_sys = ~clk_sys;
  clsro_exec clsro_exec_inst (.clk_sys(clk_sys), .rst_b(rst_b),
    .ins_valid(ins_valid), .ins_op(ins_op), .ins_b1(ins_b1),
    .ins_b2(ins_b2), .irq_enter(irq_enter), .irq_enter_hi(irq_enter_hi),
    .irq_pend_le(irq_pend_le), .busy_q(busy_q), .done_q(done_q),
    .bad_op_q(bad_op_q), .acc_q(acc_q), .psw_q(psw_q), .sp_q(sp_q),
    .pc_q(pc_q), .port1_q(port1_q), .in_svc_q(in_svc_q),
    .irq_hold_q(irq_hold_q));
  task chk(input [63:0] nm, input [15:0] e, input [15:0] g);
    begin
      num_checks = num_checks + 1;
      if (g !== e) begin
        bad_count = bad_count + 1;
        $display("BAD %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task close_out;
    begin
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  task rst;
    begin
      rst_b = 1'b0;
      repeat (16) @(negedge clk_sys);
      rst_b = 1'b1;
      st = {8'h07, 1'b0, 8'h00};
    end
  endtask
  // one instruction; valid drops after the first edge so it is not taken twice
  task run(input [7:0] o, input [7:0] b1, input [7:0] b2);
    begin
      ins_valid = 1'b1;
      ins_op = o;
      ins_b1 = b1;
      ins_b2 = b2;
      @(negedge clk_sys);
      ins_valid = 1'b0;
      k = 0;
      while (done_q !== 1'b1 && k < 4) begin
        @(negedge clk_sys);
        k = k + 1;
      end
      bad = bad_op_q;
      chk("done", 16'h0001, done_q);
      @(negedge clk_sys);
    end
  endtask
  function [16:0] step(input [7:0] o, input [7:0] d, input [16:0] s);
    reg [7:0] a, p;
    reg c;
    begin
      {p, c, a} = s;
      case (o)
        8'h23: a = {a[6:0], a[7]};
        8'h03: a = {a[0], a[7:1]};
        8'h33: {c, a} = {a, c};
        8'h13: {a, c} = {c, a};
        8'hD3: c = 1'b1;
        8'hD2: a = a | (8'h01 << d[2:0]);
        8'h72: c = c | a[d[2:0]];
        8'hA0: c = c | ~a[d[2:0]];
        8'h42: p = p | a;
        default: ;
      endcase
      step = {p, c, a};
    end
  endfunction
  initial begin
    #2000000;
    bad_count = bad_count + 1;
    close_out;
  end
  initial begin
    rst;
    chk("rst", 16'h07FF, {sp_q, port1_q});
    chk("pc", 16'h0000, pc_q);
    for (i = 0; i < 8; i = i + 1) begin
      rst;
      r = $random(seed);
      run(8'h44, r, 8'h00);
      st[7:0] = r;
      for (j = 0; j < 12; j = j + 1) begin
        n = {$random(seed)} % 9;
        op = OPS[8*n +: 8];
        b = (op == 8'h42) ? 8'h81 : (8'hE0 | ($random(seed) & 7));
        st = step(op, b, st);
        run(op, b, 8'h00);
        chk("acc", st[7:0], acc_q);
        chk("cy", st[8], psw_q[7]);
        chk("sp", st[16:9], sp_q);
      end
    end
    $display("random sequences done");
    rst;
    r = $random(seed);
    m = $random(seed);
    run(8'h44, r, 8'h00);
    run(8'hC0, 8'hE0, 8'h00);
    run(8'h43, 8'h08, m);
    run(8'hD0, 8'h81, 8'h00);
    chk("sp", r | m, sp_q);
    rst;
    run(8'h44, 8'hFF, 8'h00);
    run(8'h42, 8'h81, 8'h00);
    run(8'hC0, 8'hE0, 8'h00);
    chk("sp", 8'h00, sp_q);
    run(8'hD0, 8'hD0, 8'h00);
    chk("pull", 16'hFFFF, {sp_q, psw_q});
    rst;
    run(8'h44, r, 8'h00);
    run(8'hC0, 8'hE0, 8'h00);
    run(8'hD0, 8'h90, 8'h00);
    run(8'h43, 8'h90, m);
    chk("port", r | m, port1_q);
    run(8'hD2, 8'h0B, 8'h00);
    run(8'h72, 8'h0B, 8'h00);
    chk("bitcy", 16'h0001, psw_q[7]);
    $display("stack tests done");
    for (i = 0; i < 3; i = i + 1) begin
      rst;
      r = $random(seed);
      m = $random(seed);
      irq_enter_hi = i[0];
      irq_enter = 1'b1;
      @(negedge clk_sys);
      irq_enter = 1'b0;
      run(8'h44, r, 8'h00);
      run(8'hC0, 8'hE0, 8'h00);
      run(8'h44, m, 8'h00);
      run(8'hC0, 8'hE0, 8'h00);
      run(8'hD3, 8'h00, 8'h00);
      irq_pend_le = 1'b1;
      run(i ? 8'h32 : 8'h22, 8'h00, 8'h00);
      chk("pc", {r | m, r}, pc_q);
      chk("sp", 8'h07, sp_q);
      chk("psw", 8'h80, psw_q);
      chk("svc", i ? 2'b00 : 2'b01, in_svc_q);
      chk("hold", i != 0, irq_hold_q);
      irq_pend_le = 1'b0;
      run(i == 2 ? 8'hC0 : 8'hA5, 8'hE0, 8'h00);
      chk("bad", i != 2, bad);
      chk("hold", 16'h0000, irq_hold_q);
    end
    $display("exit tests done");
    close_out;
  end
endmodule
